// ### verilog/rx_fifo_set_mgr.sv
// Receive FIFO data-set manager with Wishbone register access
//
// Design decisions made here: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Two presence bits track held data sets
// - No handshake at end: presence and marker unchanged
// - Manual mode: hardware leaves marker, pointer alone
// - Auto ack advances marker, sets presence
// - Auto error keeps marker and pointer, clears presence
// - Auto iso advances; presence only if written
// - Count read while empty sets underrun
// - Count unreliable mid-reception; presence after count
// - Firmware checks presence bits, not count
// - Flush empties FIFO, resets flags, self-clears
// - Flush keeps auto, iso, size, toggle
// - Control bit layout, bits 6:5 reserved
// - Count index starts at set zero
// - Count writes toggle index, reads don't
module rx_fifo_set_mgr
   import rx_fifo_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [5:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Serial engine side
   input wire xfer_end_t xfer_end,
   input wire logic [1:0] receive_write_size,
   input wire logic seq_toggle,
   output logic receive_toggle_sequence,
   output logic [4:0] count_for_engine,
   // Interrupt
   output logic irq
);
   logic [7:0] receive_control_register;
   logic [7:0] receive_status_register;
   logic [4:0] count_ring [2];
   logic count_idx;
   logic receive_underrun_flag;
   logic [2:0] irq_status;
   logic [2:0] irq_mask;
   logic count_pending;
   logic [7:0] next_ctrl;
   logic [7:0] next_stat;
   logic [4:0] next_ring0;
   logic [4:0] next_ring1;
   logic next_idx;
   logic next_urun;
   logic [2:0] next_irq_status;
   logic [2:0] next_irq_mask;
   logic next_pending;
   logic [31:0] next_dat;
   logic next_ack;
   logic [1:0] data_set_present_bits;
   logic wr_set;
   logic rd_set;
   logic set_ev;
   logic req;
   logic wr;
   logic rd;
   logic flush;
   logic end_ev;
   logic fw_adv;
   logic fw_rev;
   logic rd_done;
   logic wrote_seen;
   logic next_wrote;

   function automatic logic hit(input logic [5:0] a, input logic [3:0] o);
      hit = (a[3:0] == o) && (a[5:4] == 2'h0);
   endfunction

   assign req = cyc_i && stb_i && !ack_o;
   assign wr = req && we_i && sel_i[0];
   assign rd = req && !we_i;
   assign flush = receive_control_register[CTRL_FLUSH];
   // Presence moves only once the count word has landed
   assign end_ev = count_pending;
   assign fw_adv = receive_control_register[CTRL_ADV];
   assign fw_rev = receive_control_register[CTRL_REV];
   assign rd_done = receive_control_register[CTRL_RDDONE];

   set_tracker u_sets (
      .clk(clk),
      .arst_n(arst_n),
      .flush(flush),
      .end_ev(end_ev),
      .ack(receive_status_register[STAT_ACK]),
      .err(receive_status_register[STAT_ERR]),
      .wrote(wrote_seen),
      .iso(receive_control_register[CTRL_ISO]),
      .auto_mode(receive_control_register[CTRL_AUTO]),
      .fw_adv(fw_adv),
      .fw_rev(fw_rev),
      .rd_done(rd_done),
      .data_set_present_bits(data_set_present_bits),
      .wr_set(wr_set),
      .rd_set(rd_set),
      .set_ev(set_ev)
   );

   always_comb begin
      next_ctrl = receive_control_register;
      next_stat = receive_status_register;
      next_ring0 = count_ring[0];
      next_ring1 = count_ring[1];
      next_idx = count_idx;
      next_urun = receive_underrun_flag;
      next_irq_status = irq_status;
      next_irq_mask = irq_mask;
      next_pending = 1'b0;
      next_wrote = wrote_seen;
      // Command bits are one-shot; hardware drops them after a cycle
      next_ctrl[CTRL_FLUSH] = 1'b0;
      next_ctrl[CTRL_RDDONE] = 1'b0;
      next_ctrl[CTRL_ADV] = 1'b0;
      next_ctrl[CTRL_REV] = 1'b0;
      if (flush) begin
         // Auto, iso, size and toggle untouched
         next_urun = 1'b0;
         next_idx = 1'b0;
         next_stat[STAT_ACK] = 1'b0;
         next_stat[STAT_ERR] = 1'b0;
      end
      if (seq_toggle) begin
         next_stat[STAT_SEQ] = ~receive_status_register[STAT_SEQ];
      end
      // Engine writes count at transfer end, then the index toggles
      if (xfer_end.done) begin
         next_stat[STAT_ACK] = xfer_end.ack;
         next_stat[STAT_ERR] = xfer_end.err;
         next_pending = 1'b1;
         // Engine fields are only valid with done, so hold them
         next_wrote = xfer_end.wrote;
         if (count_idx) begin
            next_ring1 = xfer_end.count;
         end else begin
            next_ring0 = xfer_end.count;
         end
         next_idx = ~count_idx;
      end
      if (wr && hit(adr_i, CTRL_OFS)) begin
         // Reserved bits 6:5 forced to zero
         next_ctrl = {dat_i[7], 2'h0, dat_i[4:0]};
      end
      if (wr && hit(adr_i, STAT_OFS)) begin
         next_stat[STAT_SEQ] = dat_i[STAT_SEQ];
      end
      if (wr && hit(adr_i, COUNT_OFS) && !xfer_end.done) begin
         if (count_idx) begin
            next_ring1 = dat_i[4:0];
         end else begin
            next_ring0 = dat_i[4:0];
         end
         next_idx = ~count_idx;
      end
      if (wr && adr_i == MASK_ADR) begin
         next_irq_mask = dat_i[2:0];
      end
      // Empty FIFO count read flags underrun; set beats clear
      if (rd && hit(adr_i, COUNT_OFS) && data_set_present_bits == 2'h0) begin
         next_urun = 1'b1;
      end
      if (rd && adr_i == IRQ_ADR) begin
         next_irq_status = 3'h0;
      end
      next_irq_status[IRQ_RX] = next_irq_status[IRQ_RX] | set_ev;
      next_irq_status[IRQ_URUN] = next_irq_status[IRQ_URUN] |
         (next_urun && !receive_underrun_flag);
      next_irq_status[IRQ_FLUSH] = next_irq_status[IRQ_FLUSH] | flush;
   end

   always_comb begin
      next_dat = 32'h0;
      next_ack = req;
      if (rd) begin
         case (adr_i)
            {2'h0, CTRL_OFS}: next_dat = {24'h0, receive_control_register};
            {2'h0, STAT_OFS}: next_dat = {24'h0, receive_status_register};
            // Presence comes from here, not from the count
            {2'h0, FLAG_OFS}: next_dat = {27'h0, receive_underrun_flag,
               &data_set_present_bits, ~|data_set_present_bits,
               data_set_present_bits};
            {2'h0, COUNT_OFS}: next_dat = {27'h0, count_ring[count_idx]};
            IRQ_ADR: next_dat = {29'h0, irq_status};
            MASK_ADR: next_dat = {29'h0, irq_mask};
            default: next_dat = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         // Auto-manage on by default, as firmware should run it
         receive_control_register <= CTRL_RESET;
         receive_status_register <= STAT_RESET;
         count_ring[0] <= COUNT_RESET;
         count_ring[1] <= COUNT_RESET;
         count_idx <= 1'b0;
         receive_underrun_flag <= 1'b0;
         irq_status <= 3'h0;
         irq_mask <= 3'h0;
         count_pending <= 1'b0;
         wrote_seen <= 1'b0;
         dat_o <= 32'h0;
         ack_o <= 1'b0;
      end else begin
         receive_control_register <= next_ctrl;
         receive_status_register <= next_stat;
         count_ring[0] <= next_ring0;
         count_ring[1] <= next_ring1;
         count_idx <= next_idx;
         receive_underrun_flag <= next_urun;
         irq_status <= next_irq_status;
         irq_mask <= next_irq_mask;
         count_pending <= next_pending;
         wrote_seen <= next_wrote;
         dat_o <= next_dat;
         ack_o <= next_ack;
      end
   end

   assign irq = |(irq_status & irq_mask);
   assign receive_toggle_sequence = receive_status_register[STAT_SEQ];
   assign count_for_engine = count_ring[count_idx];

   a_underrun_set: assert property (@(posedge clk) disable iff (!arst_n)
      rd && hit(adr_i, COUNT_OFS) && data_set_present_bits == 2'h0 && !flush
      |=> receive_underrun_flag)
      else $error("empty count read missed underrun");
   a_flush_keeps: assert property (@(posedge clk) disable iff (!arst_n)
      flush && !req |=> !receive_control_register[CTRL_FLUSH]
      && receive_control_register[CTRL_AUTO] ==
      $past(receive_control_register[CTRL_AUTO])
      && receive_control_register[CTRL_ISO] ==
      $past(receive_control_register[CTRL_ISO]))
      else $error("flush disturbed kept bits");
   a_count_toggle: assert property (@(posedge clk) disable iff (!arst_n)
      rd && !xfer_end.done && !flush |=> count_idx == $past(count_idx))
      else $error("count read moved index");
   a_reserved_zero: assert property (@(posedge clk) disable iff (!arst_n)
      receive_control_register[6:5] == 2'h0)
      else $error("reserved control bits set");
   a_count_first: assert property (@(posedge clk) disable iff (!arst_n)
      xfer_end.done |=> count_pending ##1 !count_pending)
      else $error("presence update not after count write");
endmodule // rx_fifo_set_mgr
`default_nettype wire

// ### verilog/rx_fifo_pkg.sv
// Package: register map, field layout and types of the receive FIFO set manager
package rx_fifo_pkg;
   // Register word offsets (byte addresses)
   localparam logic [3:0] CTRL_OFS = 4'h0;
   localparam logic [3:0] STAT_OFS = 4'h4;
   localparam logic [3:0] FLAG_OFS = 4'h8;
   localparam logic [3:0] COUNT_OFS = 4'hc;
   localparam logic [3:0] IRQ_OFS = 4'h0;
   localparam logic [3:0] MASK_OFS = 4'h4;
   localparam logic [5:0] IRQ_ADR = 6'h10;
   localparam logic [5:0] MASK_ADR = 6'h14;
   // Control register fields
   localparam int CTRL_FLUSH = 7;
   localparam int CTRL_RDDONE = 4;
   localparam int CTRL_ISO = 3;
   localparam int CTRL_AUTO = 2;
   localparam int CTRL_ADV = 1;
   localparam int CTRL_REV = 0;
   localparam logic [7:0] CTRL_RESET = 8'h04;
   // Status register fields
   localparam int STAT_ACK = 0;
   localparam int STAT_ERR = 1;
   localparam int STAT_SEQ = 2;
   localparam logic [7:0] STAT_RESET = 8'h00;
   // Flag register fields
   localparam int FLAG_PRES = 0;
   localparam int FLAG_EMPTY = 2;
   localparam int FLAG_FULL = 3;
   localparam int FLAG_URUN = 4;
   localparam logic [4:0] COUNT_RESET = 5'h00;
   // Interrupt status bits
   localparam int IRQ_RX = 0;
   localparam int IRQ_URUN = 1;
   localparam int IRQ_FLUSH = 2;
   // Transfer end report from the serial engine
   typedef struct packed {
      logic done;
      logic ack;
      logic err;
      logic wrote;
      logic [4:0] count;
   } xfer_end_t;
endpackage

// ### verilog/set_tracker.sv
// Two-set presence, marker and pointer tracking of the receive FIFO
`timescale 1ns/1ps
`default_nettype none
module set_tracker
   import rx_fifo_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Controls
   input wire logic flush,
   input wire logic end_ev,
   input wire logic ack,
   input wire logic err,
   input wire logic wrote,
   input wire logic iso,
   input wire logic auto_mode,
   input wire logic fw_adv,
   input wire logic fw_rev,
   input wire logic rd_done,
   // State
   output logic [1:0] data_set_present_bits,
   output logic wr_set,
   output logic rd_set,
   output logic set_ev
);
   logic [1:0] next_present;
   logic next_wr_set;
   logic next_rd_set;
   logic next_set_ev;

   function automatic logic [1:0] onehot(input logic s);
      onehot = s ? 2'h2 : 2'h1;
   endfunction

   always_comb begin
      next_present = data_set_present_bits;
      next_wr_set = wr_set;
      next_rd_set = rd_set;
      next_set_ev = 1'b0;
      if (flush) begin
         next_present = 2'h0;
         next_wr_set = 1'b0;
         next_rd_set = 1'b0;
      end else begin
         // No handshake means no action, iso or not
         if (end_ev && auto_mode && (ack || err)) begin
            if (iso) begin
               // Marker always moves; set held only if bytes landed
               next_wr_set = ~wr_set;
               if (wrote) begin
                  next_present = next_present | onehot(wr_set);
                  next_set_ev = 1'b1;
               end
            end else if (ack) begin
               next_present = next_present | onehot(wr_set);
               next_wr_set = ~wr_set;
               next_set_ev = 1'b1;
            end else begin
               next_present = next_present & ~onehot(wr_set);
            end
         end
         // Firmware steering; advance and reverse only when hardware management is off
         if (!auto_mode && fw_adv) begin
            next_present = next_present | onehot(wr_set);
            next_wr_set = ~wr_set;
            next_set_ev = 1'b1;
         end
         if (!auto_mode && fw_rev) begin
            next_present = next_present & ~onehot(wr_set);
         end
         if (rd_done && |data_set_present_bits) begin
            next_present = next_present & ~onehot(rd_set);
            next_rd_set = ~rd_set;
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         data_set_present_bits <= 2'h0;
         wr_set <= 1'b0;
         rd_set <= 1'b0;
         set_ev <= 1'b0;
      end else begin
         data_set_present_bits <= next_present;
         wr_set <= next_wr_set;
         rd_set <= next_rd_set;
         set_ev <= next_set_ev;
      end
   end

   a_idle_no_change: assert property (@(posedge clk) disable iff (!arst_n)
      end_ev && !ack && !err && !flush && !fw_adv && !fw_rev && !rd_done
      |=> data_set_present_bits == $past(data_set_present_bits))
      else $error("presence changed on idle transfer end");
   a_manual_hold: assert property (@(posedge clk) disable iff (!arst_n)
      end_ev && !auto_mode && !flush && !fw_adv && !fw_rev && !rd_done
      |=> $stable(wr_set) && $stable(data_set_present_bits))
      else $error("state moved with hardware management off");
   a_ack_sets: assert property (@(posedge clk) disable iff (!arst_n)
      end_ev && ack && auto_mode && !iso && !flush && !rd_done
      |=> data_set_present_bits[$past(wr_set)] && wr_set != $past(wr_set))
      else $error("ack did not mark set present");
   a_err_clears: assert property (@(posedge clk) disable iff (!arst_n)
      end_ev && err && !ack && auto_mode && !iso && !flush && !fw_adv
      |=> !data_set_present_bits[$past(wr_set)] && $stable(wr_set))
      else $error("error did not drop the set");
   a_iso_advance: assert property (@(posedge clk) disable iff (!arst_n)
      end_ev && iso && auto_mode && (ack || err) && !flush
      |=> wr_set != $past(wr_set))
      else $error("isochronous end did not advance marker");
   a_flush_empty: assert property (@(posedge clk) disable iff (!arst_n)
      flush |=> data_set_present_bits == 2'h0 && !wr_set)
      else $error("flush left data behind");
endmodule // set_tracker
`default_nettype wire

// ### verif/engine_model.sv
// Serial engine model that reports transfer ends to the block
`timescale 1ns/1ps
`default_nettype none
module engine_model
   import rx_fifo_pkg::*;
(
   // Clock
   input wire logic clk,
   // Toward the block
   output var xfer_end_t xfer_end,
   output logic seq_toggle
);
   logic go = 1'b0;
   logic tog = 1'b0;
   logic [7:0] pend;
   initial begin
      xfer_end = '0;
      seq_toggle = 1'b0;
   end
   // Fields scramble while idle so stale values are never trusted
   always @(posedge clk) begin
      seq_toggle <= tog;
      tog = 1'b0;
      if (go) begin
         xfer_end <= {1'b1, pend};
         go = 1'b0;
      end else begin
         xfer_end <= {1'b0, ~xfer_end[7:0]};
      end
   end
   // Count rides with the done pulse, never ahead of it
   task automatic send(input logic [7:0] f);
      @(negedge clk);
      pend = f;
      go = 1'b1;
      repeat (5) @(posedge clk);
   endtask
   task automatic toggle();
      @(negedge clk);
      tog = 1'b1;
      repeat (2) @(posedge clk);
   endtask
endmodule // engine_model
`default_nettype wire

// ### verif/usb_rx_fifo_dataset_manager_test.sv
// Self-checking bench of the receive FIFO data-set manager
`timescale 1ns/1ps
`default_nettype none
module usb_rx_fifo_dataset_manager_test
   import rx_fifo_pkg::*;
;
   localparam logic [5:0] A_CTRL = {2'h0, CTRL_OFS};
   localparam logic [5:0] A_STAT = {2'h0, STAT_OFS};
   localparam logic [5:0] A_FLAG = {2'h0, FLAG_OFS};
   localparam logic [5:0] A_CNT = {2'h0, COUNT_OFS};
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [5:0] adr = 6'h00;
   logic [31:0] dat = 32'h0;
   logic [1:0] wsize = 2'h0;
   logic [31:0] dat_o;
   logic ack_o;
   logic irq;
   logic seq_out;
   logic [4:0] cnt_eng;
   logic seq_toggle;
   xfer_end_t xfer_end;
   int fails = 0;
   int checks_done = 0;
   int cycles = 0;
   // Reference state
   logic [1:0] pres;
   logic wr;
   logic rd;
   logic urun;
   logic [7:0] q;

   engine_model u_engine (.clk(clk), .xfer_end(xfer_end),
      .seq_toggle(seq_toggle));
   rx_fifo_set_mgr u_rx_fifo_set_mgr (.clk(clk), .arst_n(arst_n),
      .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'h1),
      .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .xfer_end(xfer_end),
      .receive_write_size(wsize), .seq_toggle(seq_toggle),
      .receive_toggle_sequence(seq_out), .count_for_engine(cnt_eng),
      .irq(irq));

   initial begin
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         $display("[ERR] %0t timeout", $time);
         results();
      end
   end

   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      checks_done++;
      if (s !== e) begin
         fails++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   // Classic cycle; no fixed answer time is assumed
   task automatic wb(input logic w, input logic [5:0] a,
      input logic [7:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= {24'h0, d};
      do begin
         @(posedge clk);
      end while (ack_o !== 1'b1);
      q = dat_o[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic rdflags();
      wb(1'b0, A_FLAG, 8'h00);
      chk(q, {3'h0, urun, &pres, ~|pres, pres});
   endtask
   task automatic flush(input logic [7:0] ctl);
      wb(1'b1, A_CTRL, 8'h80 | ctl);
      {pres, wr, rd, urun} = '0;
      wb(1'b0, A_CTRL, 8'h00);
      chk(q, ctl & 8'h1c);
   endtask
   task automatic end_xfer(input logic iso, input logic auto_on,
      input logic a, input logic e, input logic w);
      u_engine.send({a, e, w, 5'($urandom)});
      if (auto_on && (a || e)) begin
         if (iso) begin
            if (w)
               pres[wr] = 1'b1;
            wr = ~wr;
         end else if (a && !e) begin
            pres[wr] = 1'b1;
            wr = ~wr;
         end else if (e && !a) begin
            pres[wr] = 1'b0;
         end
      end
   endtask

   initial begin
      void'($urandom(32'h6b88));
      wsize = 2'($urandom);
      {pres, wr, rd, urun} = '0;
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      wb(1'b0, A_CTRL, 8'h00);
      chk(q, CTRL_RESET);
      rdflags();
      wb(1'b1, A_CNT, 8'h0a);
      wb(1'b1, A_CNT, 8'h03);
      wb(1'b0, A_CNT, 8'h00);
      chk(q, 8'h0a);
      wb(1'b0, A_CNT, 8'h00);
      chk(q, 8'h0a);
      chk({3'h0, cnt_eng}, 8'h0a);
      urun = 1'b1;
      rdflags();
      $display("test reset_and_count done");
      u_engine.toggle();
      flush(8'h6c);
      rdflags();
      wb(1'b0, A_STAT, 8'h00);
      chk(q & 8'h04, 8'h04);
      chk({7'h0, seq_out}, 8'h01);
      $display("test flush done");
      for (int m = 0; m < 4; m++) begin
         for (int k = 0; k < 4; k++) begin
            if (k == 3 && m != 3)
               continue;
            flush({4'h0, m[1], m[0], 2'h0});
            repeat (2) begin
               end_xfer(m[1], m[0], k[0], k[1], 1'($urandom));
               rdflags();
            end
         end
      end
      $display("test handshake_table done");
      // Manual steering, with auto-manage off here as in the m=0 and m=2 handshake_table rows
      flush(8'h00);
      repeat (2) begin
         wb(1'b1, A_CTRL, 8'h02);
         pres[wr] = 1'b1;
         wr = ~wr;
         rdflags();
      end
      wb(1'b1, A_CTRL, 8'h10);
      pres[rd] = 1'b0;
      rd = ~rd;
      rdflags();
      wb(1'b1, A_CTRL, 8'h02);
      pres[wr] = 1'b1;
      wr = ~wr;
      rdflags();
      wb(1'b1, A_CTRL, 8'h01);
      pres[wr] = 1'b0;
      rdflags();
      $display("test manual done");
      flush(8'h04);
      wb(1'b0, IRQ_ADR, 8'h00);
      chk(q & 8'h04, 8'h04);
      wb(1'b1, MASK_ADR, 8'h01);
      @(posedge clk);
      chk({7'h0, irq}, 8'h00);
      end_xfer(1'b0, 1'b1, 1'b1, 1'b0, 1'b1);
      chk({7'h0, irq}, 8'h01);
      wb(1'b0, IRQ_ADR, 8'h00);
      chk(q & 8'h01, 8'h01);
      @(posedge clk);
      chk({7'h0, irq}, 8'h00);
      wb(1'b1, MASK_ADR, 8'h00);
      end_xfer(1'b0, 1'b1, 1'b1, 1'b0, 1'b1);
      chk({7'h0, irq}, 8'h00);
      rdflags();
      $display("test interrupt done");
      results();
   end
endmodule // usb_rx_fifo_dataset_manager_test
`default_nettype wire
